// ---- rtl/chan_if.sv ----
`timescale 1ns/1ps
interface chan_if;
    import remote_io_pkg::*;
    logic [4:0] filter_len;
    trig_mode_t trig;
    logic clear;
    logic state;
    logic [CNT_W-1:0] count;

    modport channel (input filter_len, input trig, input clear, output state, output count);
    modport ctrl (output filter_len, output trig, output clear, input state, input count);
endinterface : chan_if

// ---- rtl/remote_io_pkg.sv ----
package remote_io_pkg;

    localparam int NUM_IN = 4;
    localparam int NUM_OUT = 2;
    localparam int CNT_W = 16;

    // sampling tick
    localparam int CLK_HZ = 100_000_000;
    localparam int SAMPLE_PERIOD_US = 1000;
    localparam int TICK_CYCLES = CLK_HZ / 1_000_000 * SAMPLE_PERIOD_US;

    // filter length in sampling periods
    localparam logic [4:0] FILTER_MIN = 5'h01;
    localparam logic [4:0] FILTER_MAX = 5'h10;
    localparam logic [4:0] FILTER_RESET = 5'h06;

    // pulse width in ms
    localparam logic [15:0] PULSE_MIN = 16'h0032;
    localparam logic [15:0] PULSE_RESET = 16'h0032;

    // serial link settings
    localparam logic [16:0] BAUD_MIN = 17'h004B0;
    localparam logic [16:0] BAUD_MAX = 17'h1C200;
    localparam logic [16:0] BAUD_RESET = 17'h02580;
    localparam logic [7:0] STATION_MIN = 8'h01;
    localparam logic [7:0] STATION_MAX = 8'hF7;
    localparam logic [7:0] OFFSET_RESET = 8'h01;
    localparam logic [1:0] STARTUP_CYCLES = 2'h3;

    typedef enum logic [1:0] {
        TRIG_RISE = 2'b00,
        TRIG_FALL = 2'b01,
        TRIG_LEVEL = 2'b10
    } trig_mode_t;

    typedef enum logic [1:0] {
        OUT_LEVEL = 2'b00,
        OUT_PULSE = 2'b01,
        OUT_FOLLOW = 2'b10
    } out_mode_t;

    typedef enum logic [1:0] {
        PAR_NONE = 2'b00,
        PAR_ODD = 2'b01,
        PAR_EVEN = 2'b10
    } parity_t;

    // register byte offsets
    localparam logic [7:0] REG_IN_STATE = 8'h00;
    localparam logic [7:0] REG_TRIG_MODE = 8'h04;
    localparam logic [7:0] REG_FILTER = 8'h08;
    localparam logic [7:0] REG_CLEAR = 8'h0C;
    localparam logic [7:0] REG_COUNT0 = 8'h10;
    localparam logic [7:0] REG_OUT_MODE = 8'h20;
    localparam logic [7:0] REG_OUT_CMD = 8'h24;
    localparam logic [7:0] REG_PULSE_W = 8'h28;
    localparam logic [7:0] REG_FOLLOW = 8'h2C;
    localparam logic [7:0] REG_OUT_STATE = 8'h30;
    localparam logic [7:0] REG_BAUD = 8'h34;
    localparam logic [7:0] REG_PARITY = 8'h38;
    localparam logic [7:0] REG_OFFSET = 8'h3C;
    localparam logic [7:0] REG_STATION = 8'h40;

    // field positions
    localparam int CLR_MANUAL_BIT = 0;
    localparam int CLR_CHAN_LSB = 4;

endpackage : remote_io_pkg

// ---- rtl/remote_switch_io_core.sv ----
`timescale 1ns/1ps
// How it works
// - input accepted only after staying stable 1..16 sampling periods, default 6
// - each input triggers on rising edge, falling edge or level; level after reset
// - each input has a 16-bit event counter that wraps to zero past 65535
// - counters clear automatically (on read) or manually on request; automatic by default
// - level mode output holds the last commanded on or off state
// - pulse mode output stays on for the pulse width in ms, then turns off
// - pulse width accepts 50 to 65535 ms, 50 after reset
// - follow mode output mirrors the filtered state of its chosen input
// - each output picks one input; many outputs may share one input
// - each output lights its own indicator while the relay is energised
// - link rate settable 1200 to 115200 bit/s, default 9600, master matches it
// - parity none, odd or even, none by default, same at both ends
// - only requests carrying the station address 1..247 are answered, default 1
// - station address is the 5-bit switch value plus the offset held at startup, which reset sets to 1
// - a changed switch value takes effect only after restart
module remote_switch_io_core
    import remote_io_pkg::*;
#(
    parameter int TICK_LEN = remote_io_pkg::TICK_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // register port
    input wire logic [7:0] addr,
    input wire logic [31:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [31:0] rd_data,
    // field pins
    input wire logic [remote_io_pkg::NUM_IN-1:0] switch_input,
    input wire logic [4:0] addr_switch,
    output logic [remote_io_pkg::NUM_OUT-1:0] relay_out,
    output logic [remote_io_pkg::NUM_OUT-1:0] indicator_out,
    // link settings and address check
    output logic [16:0] baud_rate,
    output remote_io_pkg::parity_t parity_mode,
    output logic [7:0] station_addr,
    input wire logic frame_valid,
    input wire logic [7:0] frame_addr,
    output logic frame_accept
);
    import remote_io_pkg::*;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction : hit

    // pin synchronisers
    logic [NUM_IN-1:0] sw_meta_reg;
    logic [NUM_IN-1:0] sw_sync_reg;
    logic [4:0] dip_meta_reg;
    logic [4:0] dip_sync_reg;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sw_meta_reg <= '0;
            sw_sync_reg <= '0;
            dip_meta_reg <= '0;
            dip_sync_reg <= '0;
        end else begin
            sw_meta_reg <= switch_input;
            sw_sync_reg <= sw_meta_reg;
            dip_meta_reg <= addr_switch;
            dip_sync_reg <= dip_meta_reg;
        end
    end

    // millisecond tick
    logic [16:0] tick_cnt_reg;
    logic tick_reg;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            tick_cnt_reg <= '0;
            tick_reg <= 1'b0;
        end else if (tick_cnt_reg == 17'(TICK_LEN - 1)) begin
            tick_cnt_reg <= '0;
            tick_reg <= 1'b1;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 17'h00001;
            tick_reg <= 1'b0;
        end
    end

    // configuration registers
    logic [4:0] filter_reg;
    trig_mode_t trig_reg [NUM_IN];
    logic manual_clr_reg;
    out_mode_t out_mode_reg [NUM_OUT];
    logic [NUM_OUT-1:0] cmd_reg;
    logic [15:0] pulse_w_reg;
    logic [1:0] follow_reg [NUM_OUT];
    logic [16:0] baud_reg;
    parity_t parity_reg;
    logic [7:0] offset_reg;
    logic [NUM_OUT-1:0] pulse_done;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            filter_reg <= FILTER_RESET;
        end else if (wr_en && hit(addr, REG_FILTER)) begin
            if (wr_data[31:5] != '0 || wr_data[4:0] > FILTER_MAX) begin
                filter_reg <= FILTER_MAX;
            end else if (wr_data[4:0] < FILTER_MIN) begin
                filter_reg <= FILTER_MIN;
            end else begin
                filter_reg <= wr_data[4:0];
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            manual_clr_reg <= 1'b0;
        end else if (wr_en && hit(addr, REG_CLEAR)) begin
            manual_clr_reg <= wr_data[CLR_MANUAL_BIT];
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pulse_w_reg <= PULSE_RESET;
        end else if (wr_en && hit(addr, REG_PULSE_W)) begin
            pulse_w_reg <= (wr_data[15:0] < PULSE_MIN) ? PULSE_MIN : wr_data[15:0];
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            baud_reg <= BAUD_RESET;
            parity_reg <= PAR_NONE;
            offset_reg <= OFFSET_RESET;
        end else if (wr_en) begin
            if (hit(addr, REG_BAUD)) begin
                if (wr_data[31:17] != '0 || wr_data[16:0] > BAUD_MAX) begin
                    baud_reg <= BAUD_MAX;
                end else if (wr_data[16:0] < BAUD_MIN) begin
                    baud_reg <= BAUD_MIN;
                end else begin
                    baud_reg <= wr_data[16:0];
                end
            end
            if (hit(addr, REG_PARITY) && wr_data[1:0] != 2'h3) begin
                parity_reg <= parity_t'(wr_data[1:0]);
            end
            if (hit(addr, REG_OFFSET)) begin
                offset_reg <= wr_data[7:0];
            end
        end
    end

    // input channels
    chan_if chan [NUM_IN] ();
    logic [NUM_IN-1:0] in_state;
    logic [CNT_W-1:0] in_count [NUM_IN];

    genvar gi;
    generate
        for (gi = 0; gi < NUM_IN; gi++) begin : g_in
            logic rd_hit;
            assign rd_hit = hit(addr, REG_COUNT0 + 8'(4 * gi));

            always_ff @(posedge clk or posedge reset) begin
                if (reset) begin
                    trig_reg[gi] <= TRIG_LEVEL;
                end else if (wr_en && hit(addr, REG_TRIG_MODE) && wr_data[2*gi+:2] != 2'h3) begin
                    trig_reg[gi] <= trig_mode_t'(wr_data[2*gi+:2]);
                end
            end

            assign chan[gi].filter_len = filter_reg;
            assign chan[gi].trig = trig_reg[gi];
            // auto: a read empties the counter; manual: only an explicit clear
            assign chan[gi].clear = manual_clr_reg
                ? (wr_en && hit(addr, REG_CLEAR) && wr_data[CLR_CHAN_LSB + gi])
                : (rd_en && rd_hit);
            assign in_state[gi] = chan[gi].state;
            assign in_count[gi] = chan[gi].count;

            switch_channel u_chan (
                .clk(clk),
                .reset(reset),
                .tick(tick_reg),
                .sample(sw_sync_reg[gi]),
                .ch(chan[gi])
            );
        end
    endgenerate

    // relay outputs
    logic [NUM_OUT-1:0] relay_reg;
    logic [NUM_OUT-1:0] led_reg;
    logic [15:0] pulse_cnt_reg [NUM_OUT];

    genvar go;
    generate
        for (go = 0; go < NUM_OUT; go++) begin : g_out
            logic cmd_write;
            assign cmd_write = wr_en && hit(addr, REG_OUT_CMD);

            always_ff @(posedge clk or posedge reset) begin
                if (reset) begin
                    out_mode_reg[go] <= OUT_LEVEL;
                    follow_reg[go] <= 2'h0;
                end else if (wr_en) begin
                    if (hit(addr, REG_OUT_MODE) && wr_data[2*go+:2] != 2'h3) begin
                        out_mode_reg[go] <= out_mode_t'(wr_data[2*go+:2]);
                    end
                    if (hit(addr, REG_FOLLOW)) begin
                        // a single index field: one source per output, shared freely
                        follow_reg[go] <= wr_data[2*go+:2];
                    end
                end
            end

            always_ff @(posedge clk or posedge reset) begin
                if (reset) begin
                    cmd_reg[go] <= 1'b0;
                end else if (cmd_write) begin
                    cmd_reg[go] <= wr_data[go];
                end else if (pulse_done[go]) begin
                    cmd_reg[go] <= 1'b0;
                end
            end

            // width counted in whole ticks, so the first ms may run short by < 1 ms
            always_ff @(posedge clk or posedge reset) begin
                if (reset) begin
                    pulse_cnt_reg[go] <= '0;
                end else if (cmd_write && wr_data[go] && out_mode_reg[go] == OUT_PULSE) begin
                    pulse_cnt_reg[go] <= pulse_w_reg;
                end else if (tick_reg && pulse_cnt_reg[go] != '0) begin
                    pulse_cnt_reg[go] <= pulse_cnt_reg[go] - 16'h0001;
                end
            end

            assign pulse_done[go] = out_mode_reg[go] == OUT_PULSE && cmd_reg[go] && !cmd_write
                && tick_reg && pulse_cnt_reg[go] == 16'h0001;

            always_ff @(posedge clk or posedge reset) begin
                if (reset) begin
                    relay_reg[go] <= 1'b0;
                    led_reg[go] <= 1'b0;
                end else begin
                    case (out_mode_reg[go])
                        OUT_LEVEL: relay_reg[go] <= cmd_reg[go];
                        OUT_PULSE: relay_reg[go] <= cmd_reg[go] && !pulse_done[go];
                        OUT_FOLLOW: relay_reg[go] <= in_state[follow_reg[go]];
                        default: relay_reg[go] <= 1'b0;
                    endcase
                    case (out_mode_reg[go])
                        OUT_LEVEL: led_reg[go] <= cmd_reg[go];
                        OUT_PULSE: led_reg[go] <= cmd_reg[go] && !pulse_done[go];
                        OUT_FOLLOW: led_reg[go] <= in_state[follow_reg[go]];
                        default: led_reg[go] <= 1'b0;
                    endcase
                end
            end
        end
    endgenerate

    // station address, fixed once after reset release
    logic [1:0] startup_reg;
    logic [7:0] station_reg;
    logic [8:0] station_sum;
    logic accept_reg;

    assign station_sum = {4'h0, dip_sync_reg} + {1'b0, offset_reg};

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            startup_reg <= '0;
        end else if (startup_reg != STARTUP_CYCLES) begin
            startup_reg <= startup_reg + 2'h1;
        end
    end

    // later offset writes go unused; reset puts the offset back to 1 before the next load
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            station_reg <= OFFSET_RESET;
        end else if (startup_reg == STARTUP_CYCLES - 2'h1) begin
            station_reg <= station_sum[8] ? 8'h00 : station_sum[7:0];
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            accept_reg <= 1'b0;
        end else begin
            accept_reg <= frame_valid && startup_reg == STARTUP_CYCLES
                && station_reg >= STATION_MIN && station_reg <= STATION_MAX
                && frame_addr == station_reg;
        end
    end

    // register read port
    logic [31:0] rd_data_reg;
    logic [31:0] rd_mux;

    always_comb begin
        rd_mux = 32'h0000_0000;
        case (addr)
            REG_IN_STATE: rd_mux = {28'h0, in_state};
            REG_TRIG_MODE: rd_mux = {24'h0, trig_reg[3], trig_reg[2], trig_reg[1], trig_reg[0]};
            REG_FILTER: rd_mux = {27'h0, filter_reg};
            REG_CLEAR: rd_mux = {31'h0, manual_clr_reg};
            REG_COUNT0: rd_mux = {16'h0, in_count[0]};
            REG_COUNT0 + 8'h04: rd_mux = {16'h0, in_count[1]};
            REG_COUNT0 + 8'h08: rd_mux = {16'h0, in_count[2]};
            REG_COUNT0 + 8'h0C: rd_mux = {16'h0, in_count[3]};
            REG_OUT_MODE: rd_mux = {28'h0, out_mode_reg[1], out_mode_reg[0]};
            REG_OUT_CMD: rd_mux = {30'h0, cmd_reg};
            REG_PULSE_W: rd_mux = {16'h0, pulse_w_reg};
            REG_FOLLOW: rd_mux = {28'h0, follow_reg[1], follow_reg[0]};
            REG_OUT_STATE: rd_mux = {30'h0, relay_reg};
            REG_BAUD: rd_mux = {15'h0, baud_reg};
            REG_PARITY: rd_mux = {30'h0, parity_reg};
            REG_OFFSET: rd_mux = {24'h0, offset_reg};
            REG_STATION: rd_mux = {24'h0, station_reg};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rd_data_reg <= 32'h0000_0000;
        end else if (rd_en) begin
            rd_data_reg <= rd_mux;
        end else begin
            rd_data_reg <= 32'h0000_0000;
        end
    end

    assign rd_data = rd_data_reg;
    assign relay_out = relay_reg;
    assign indicator_out = led_reg;
    assign baud_rate = baud_reg;
    assign parity_mode = parity_reg;
    assign station_addr = station_reg;
    assign frame_accept = accept_reg;

endmodule : remote_switch_io_core

// ---- rtl/switch_channel.sv ----
`timescale 1ns/1ps
module switch_channel (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // sampling
    input wire logic tick,
    input wire logic sample,
    // control and status
    chan_if.channel ch
);
    import remote_io_pkg::*;

    logic state_reg;
    logic [4:0] stable_reg;
    logic [CNT_W-1:0] count_reg;
    logic accept;
    logic event_hit;

    assign accept = tick && (sample != state_reg) && (stable_reg + 5'h01 >= ch.filter_len);

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            stable_reg <= 5'h00;
        end else if (tick) begin
            // any sample equal to the accepted state restarts the run
            if (sample == state_reg || accept) begin
                stable_reg <= 5'h00;
            end else begin
                stable_reg <= stable_reg + 5'h01;
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_reg <= 1'b0;
        end else if (accept) begin
            state_reg <= sample;
        end
    end

    always_comb begin
        case (ch.trig)
            TRIG_RISE: event_hit = accept && sample;
            TRIG_FALL: event_hit = accept && !sample;
            TRIG_LEVEL: event_hit = accept && sample;
            default: event_hit = 1'b0;
        endcase
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            count_reg <= '0;
        end else if (event_hit) begin
            // event beats a clear in the same cycle; 16-bit add wraps to zero
            count_reg <= ch.clear ? 16'h0001 : count_reg + 16'h0001;
        end else if (ch.clear) begin
            count_reg <= '0;
        end
    end

    assign ch.state = state_reg;
    assign ch.count = count_reg;

endmodule : switch_channel

// ---- verif/link_master_model.sv ----
`timescale 1ns/1ps
module link_master_model #(
    parameter logic [16:0] LINK_BAUD = 17'h02580,
    parameter logic [1:0] LINK_PARITY = 2'h0
) (
    // clock
    input wire logic clk,
    // frame address path
    output logic frame_valid,
    output logic [7:0] frame_addr,
    input wire logic frame_accept
);
    initial begin
        frame_valid = 1'b0;
        frame_addr = 8'hA5;
    end

    // released address line shows the inverse, never the stale byte
    task automatic send_frame(input logic [7:0] station, output logic accepted);
        @(posedge clk);
        frame_valid <= 1'b1;
        frame_addr <= station;
        @(posedge clk);
        frame_valid <= 1'b0;
        frame_addr <= ~station;
        #1;
        accepted = frame_accept;
    endtask : send_frame
endmodule : link_master_model

// ---- verif/remote_io_chk.sv ----
`timescale 1ns/1ps
module remote_io_chk
    import remote_io_pkg::*;
#(
    parameter int TICK_LEN = 10
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // register port
    input wire logic [7:0] addr,
    input wire logic rd_en,
    input wire logic [31:0] rd_data,
    // field pins
    input wire logic [remote_io_pkg::NUM_OUT-1:0] relay_out,
    input wire logic [remote_io_pkg::NUM_OUT-1:0] indicator_out,
    // link
    input wire logic [16:0] baud_rate,
    input wire remote_io_pkg::parity_t parity_mode,
    input wire logic [7:0] station_addr,
    input wire logic frame_valid,
    input wire logic [7:0] frame_addr,
    input wire logic frame_accept
);
    import remote_io_pkg::*;

    // edges since reset, saturating; the address settles during startup
    logic [2:0] run_cnt;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            run_cnt <= 3'h0;
        end else if (run_cnt != 3'h7) begin
            run_cnt <= run_cnt + 3'h1;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence frame_for_us;
        frame_valid && run_cnt >= 3'h4 && frame_addr == station_addr
            && station_addr != 8'h00 && station_addr <= STATION_MAX;
    endsequence

    sequence station_read;
        rd_en && addr == REG_STATION;
    endsequence

    a_ind_mirrors_relay: assert property (indicator_out == relay_out)
        else $error("indicator differs from relay");
    a_accept_match: assert property (frame_for_us |=> frame_accept)
        else $error("frame for our station not accepted");
    a_accept_cause: assert property (frame_accept |->
        $past(frame_valid) && $past(frame_addr) == $past(station_addr))
        else $error("accept without matching frame");
    a_station_read: assert property (station_read |=>
        rd_data == {24'h000000, $past(station_addr)})
        else $error("station read back differs");
    a_station_fixed: assert property (run_cnt == 3'h7 |-> $stable(station_addr))
        else $error("station changed while running");
    a_station_range: assert property (run_cnt == 3'h7 |-> station_addr <= STATION_MAX)
        else $error("station above range");
    a_baud_bounds: assert property (baud_rate >= BAUD_MIN && baud_rate <= BAUD_MAX)
        else $error("baud rate out of range");
    a_parity_legal: assert property (parity_mode != 2'b11)
        else $error("illegal parity code");
endmodule : remote_io_chk

// ---- verif/tb_remote_switch_io_core.sv ----
`timescale 1ns/1ps
module tb_remote_switch_io_core;
    import remote_io_pkg::*;
    // short tick keeps millisecond timers cheap
    localparam int TICK = 10;
    logic clk;
    logic reset;
    logic [7:0] addr;
    logic [31:0] wr_data;
    logic wr_en;
    logic rd_en;
    logic [31:0] rd_data;
    logic [NUM_IN-1:0] switch_input;
    logic [4:0] addr_switch;
    logic [NUM_OUT-1:0] relay_out;
    logic [NUM_OUT-1:0] indicator_out;
    logic [16:0] baud_rate;
    parity_t parity_mode;
    logic [7:0] station_addr;
    logic frame_valid;
    logic [7:0] frame_addr;
    logic frame_accept;
    logic acc;
    int failures;
    int tests_run;

    remote_switch_io_core #(.TICK_LEN(TICK)) dut_u (
        .clk(clk), .reset(reset), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
        .rd_en(rd_en), .rd_data(rd_data), .switch_input(switch_input),
        .addr_switch(addr_switch), .relay_out(relay_out), .indicator_out(indicator_out),
        .baud_rate(baud_rate), .parity_mode(parity_mode), .station_addr(station_addr),
        .frame_valid(frame_valid), .frame_addr(frame_addr), .frame_accept(frame_accept));

    link_master_model master_u (.clk(clk), .frame_valid(frame_valid),
        .frame_addr(frame_addr), .frame_accept(frame_accept));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc

    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk32

    task automatic chk2(input logic [1:0] got, input logic [1:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: outputs %b expected %b", $time, got, exp);
        end
    endtask : chk2

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask : wr

    task automatic rd_exp(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        chk32(rd_data, exp);
    endtask : rd_exp

    task automatic out_exp(input logic [1:0] exp);
        #1;
        chk2(relay_out, exp);
        chk2(indicator_out, exp);
    endtask : out_exp

    task automatic set_in(input int ch, input logic v, input int wait_n);
        @(posedge clk);
        switch_input[ch] <= v;
        cyc(wait_n);
    endtask : set_in

    task automatic do_reset;
        reset <= 1'b1;
        cyc(20);
        reset <= 1'b0;
        cyc(4);
    endtask : do_reset

    task automatic t_defaults;
        rd_exp(REG_TRIG_MODE, 32'h000000AA);
        rd_exp(REG_FILTER, 32'h00000006);
        rd_exp(REG_CLEAR, 32'h00000000);
        rd_exp(REG_PULSE_W, 32'h00000032);
        rd_exp(REG_BAUD, 32'h00002580);
        rd_exp(REG_PARITY, 32'h00000000);
        rd_exp(REG_STATION, 32'h00000001);
        rd_exp(8'h80, 32'h00000000);
    endtask : t_defaults

    task automatic t_filter;
        wr(REG_FILTER, 32'h00000000);
        rd_exp(REG_FILTER, 32'h00000001);
        wr(REG_FILTER, 32'h00000020);
        rd_exp(REG_FILTER, 32'h00000010);
        wr(REG_FILTER, 32'h00000003);
        set_in(0, 1'b1, 10);
        rd_exp(REG_IN_STATE, 32'h00000000);
        cyc(30);
        rd_exp(REG_IN_STATE, 32'h00000001);
        set_in(0, 1'b0, 40);
        wr(REG_FILTER, 32'h00000001);
    endtask : t_filter

    task automatic t_counts;
        rd_exp(REG_COUNT0, 32'h00000001);
        rd_exp(REG_COUNT0, 32'h00000000);
        wr(REG_TRIG_MODE, 32'h00000086);
        wr(REG_TRIG_MODE, 32'h000000FF);
        rd_exp(REG_TRIG_MODE, 32'h00000086);
        set_in(1, 1'b1, 0);
        set_in(2, 1'b1, 20);
        rd_exp(8'h14, 32'h00000000);
        rd_exp(8'h18, 32'h00000001);
        set_in(1, 1'b0, 0);
        set_in(2, 1'b0, 20);
        rd_exp(8'h14, 32'h00000001);
        rd_exp(8'h18, 32'h00000000);
        wr(REG_CLEAR, 32'h00000001);
        set_in(3, 1'b1, 20);
        set_in(3, 1'b0, 20);
        rd_exp(8'h1C, 32'h00000001);
        rd_exp(8'h1C, 32'h00000001);
        wr(REG_CLEAR, 32'h00000081);
        rd_exp(8'h1C, 32'h00000000);
        wr(REG_CLEAR, 32'h00000000);
    endtask : t_counts

    task automatic t_level_out;
        wr(REG_OUT_CMD, 32'h00000001);
        cyc(2);
        out_exp(2'b01);
        cyc(50);
        out_exp(2'b01);
        rd_exp(REG_OUT_STATE, 32'h00000001);
        wr(REG_OUT_CMD, 32'h00000000);
        cyc(2);
        out_exp(2'b00);
    endtask : t_level_out

    task automatic t_pulse_out;
        wr(REG_OUT_MODE, 32'h00000001);
        wr(REG_PULSE_W, 32'h0000000A);
        rd_exp(REG_PULSE_W, 32'h00000032);
        wr(REG_PULSE_W, 32'h0000003C);
        rd_exp(REG_PULSE_W, 32'h0000003C);
        wr(REG_OUT_CMD, 32'h00000001);
        cyc(2);
        out_exp(2'b01);
        cyc(540);
        out_exp(2'b01);
        cyc(80);
        out_exp(2'b00);
    endtask : t_pulse_out

    task automatic t_follow_out;
        wr(REG_OUT_MODE, 32'h0000000A);
        wr(REG_FOLLOW, 32'h00000005);
        set_in(1, 1'b1, 20);
        out_exp(2'b11);
        set_in(1, 1'b0, 20);
        out_exp(2'b00);
    endtask : t_follow_out

    task automatic t_link_cfg;
        wr(REG_BAUD, 32'h00000064);
        rd_exp(REG_BAUD, 32'h000004B0);
        wr(REG_BAUD, 32'h00020000);
        rd_exp(REG_BAUD, 32'h0001C200);
        wr(REG_PARITY, 32'h00000002);
        wr(REG_PARITY, 32'h00000003);
        rd_exp(REG_PARITY, 32'h00000002);
        chk32({30'h0, parity_mode}, 32'h00000002);
        wr(REG_BAUD, {15'h0, master_u.LINK_BAUD});
        wr(REG_PARITY, {30'h0, master_u.LINK_PARITY});
        cyc(1);
        #1;
        chk32({15'h0, baud_rate}, 32'h00002580);
    endtask : t_link_cfg

    task automatic t_station;
        master_u.send_frame(8'h01, acc);
        chk32({31'h0, acc}, 32'h00000001);
        master_u.send_frame(8'h02, acc);
        chk32({31'h0, acc}, 32'h00000000);
        wr(REG_OFFSET, 32'h00000005);
        rd_exp(REG_OFFSET, 32'h00000005);
        rd_exp(REG_STATION, 32'h00000001);
        master_u.send_frame(8'h06, acc);
        chk32({31'h0, acc}, 32'h00000000);
        @(posedge clk);
        addr_switch <= 5'h03;
        do_reset();
        rd_exp(REG_STATION, 32'h00000004);
        master_u.send_frame(8'h04, acc);
        chk32({31'h0, acc}, 32'h00000001);
    endtask : t_station

    task automatic test_done;
        $display("checks %0d, mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : test_done

    initial begin
        failures = 0;
        tests_run = 0;
        reset = 1'b1;
        addr = 8'h00;
        wr_data = 32'h00000000;
        wr_en = 1'b0;
        rd_en = 1'b0;
        switch_input = 4'h0;
        addr_switch = 5'h00;
        do_reset();
        t_defaults();
        t_filter();
        t_counts();
        t_level_out();
        t_pulse_out();
        t_follow_out();
        t_link_cfg();
        t_station();
        test_done();
    end

    // hang guard
    initial begin
        repeat (100000) @(posedge clk);
        failures++;
        test_done();
    end
endmodule : tb_remote_switch_io_core

bind remote_switch_io_core remote_io_chk #(.TICK_LEN(TICK_LEN)) chk_u (
    .clk(clk), .reset(reset), .addr(addr), .rd_en(rd_en), .rd_data(rd_data),
    .relay_out(relay_out), .indicator_out(indicator_out), .baud_rate(baud_rate),
    .parity_mode(parity_mode), .station_addr(station_addr), .frame_valid(frame_valid),
    .frame_addr(frame_addr), .frame_accept(frame_accept));
